// File: design/link_pkg.sv
package link_pkg;

  // byte and buffer shape
  localparam int BYTE_W    = 8;
  localparam int BUF_DEPTH = 2;

  // host mode command values
  localparam logic [7:0] CMD_HOLD    = 8'h10;
  localparam logic [7:0] CMD_RELEASE = 8'h00;

  // fixed frame bit levels
  localparam logic START_BIT   = 1'h0;
  localparam logic SOURCE_BIT  = 1'h0;
  localparam logic DESTINATION_SELECT_BIT_WRITE  = 1'h0;
  localparam logic IDLE_LEVEL  = 1'h1;

  // bit counters inside a frame
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] RX_LAST    = 4'h7;
  localparam logic [3:0] TX_LAST    = 4'h9;

  // reset values
  localparam logic HELD_RESET = 1'h0;
  localparam logic CTS_RESET  = 1'h0;
  localparam logic OUT_RESET  = 1'h1;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_DATA = 3'h2,
    RX_DESTINATION_SELECT_BIT = 3'h4
  } rx_state_t;

endpackage

// File: design/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = link_pkg::BYTE_W,
  parameter int DEPTH = link_pkg::BUF_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output wire logic             in_ready_o,
  output wire logic             out_valid_o,
  output wire logic [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic       push;
  logic       pop;

  assign in_ready_o  = (state_reg.count != FULL_COUNT);
  assign out_valid_o = (state_reg.count != '0);
  assign out_data_o  = state_reg.mem[state_reg.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && (state_reg.wr_ptr == PTR_W'(i))) begin
        state_next.mem[i] = in_data_i;
      end
    end
    if (push) begin
      state_next.wr_ptr = (state_reg.wr_ptr == LAST_PTR) ? '0 :
                          state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = (state_reg.rd_ptr == LAST_PTR) ? '0 :
                          state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
    if (reset_i) begin
      state_next = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state_reg <= state_next;
  end

endmodule

// File: design/serial_link.sv
`timescale 1ns/100ps
// How it works
// - four one-way wires: clock, out, in, cts
// - hold command 0x10 stops sending, keeps accepting
// - release command 0x00 resumes sending buffered bytes
// - outgoing frame opens with low start bit
// - no outgoing start while a frame arrives
// - eight outgoing data bits, lsb first
// - outgoing frame closes with source bit zero
// - cts drops on rising edge after start
// - incoming bits 0 to 7 lsb first
// - incoming frame ends with destination bit zero
// - cts stays low until buffer has room
module serial_link (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       host_mode_valid_i,
  input  wire logic [7:0] host_mode_value_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output wire logic       tx_ready_o,
  output wire logic       rx_valid_o,
  output wire logic [7:0] rx_data_o,
  input  wire logic       rx_ready_i,
  input  wire logic       link_clock_in_i,
  input  wire logic       serial_in_line_i,
  output wire logic       serial_out_line_o,
  output wire logic       clear_to_send_line_o,
  output wire logic       link_held_o
);

  typedef struct packed {
    logic                clk_meta;
    logic                clk_sync;
    logic                clk_prev;
    logic                din_meta;
    logic                din_sync;
    logic                held;
    link_pkg::tx_state_t tx_state;
    logic [3:0]          tx_count;
    logic [8:0]          tx_shift;
    logic                out_line;
    link_pkg::rx_state_t rx_state;
    logic [3:0]          rx_count;
    logic [7:0]          rx_shift;
    logic                cts;
    logic                rx_push;
  } state_t;

  state_t     state_reg;
  state_t     state_next;
  logic       link_rise;
  logic       link_fall;
  logic       rx_busy;
  logic       tx_pop;
  logic       txb_valid;
  logic [7:0] txb_data;
  logic       rxb_ready;

  // outgoing bytes wait here, also across a hold
  two_entry_buffer #(
    .WIDTH (link_pkg::BYTE_W),
    .DEPTH (link_pkg::BUF_DEPTH)
  ) tx_buffer (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (tx_valid_i),
    .in_data_i   (tx_data_i),
    .in_ready_o  (tx_ready_o),
    .out_valid_o (txb_valid),
    .out_data_o  (txb_data),
    .out_ready_i (tx_pop)
  );

  // incoming bytes; a full buffer keeps cts low
  two_entry_buffer #(
    .WIDTH (link_pkg::BYTE_W),
    .DEPTH (link_pkg::BUF_DEPTH)
  ) rx_buffer (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (state_reg.rx_push),
    .in_data_i   (state_reg.rx_shift),
    .in_ready_o  (rxb_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_data_o),
    .out_ready_i (rx_ready_i)
  );

  // edges found on the synchronised clock
  assign link_rise = state_reg.clk_sync && !state_reg.clk_prev;
  assign link_fall = !state_reg.clk_sync && state_reg.clk_prev;

  assign serial_out_line_o    = state_reg.out_line;
  assign clear_to_send_line_o = state_reg.cts;
  assign link_held_o          = state_reg.held;

  always_comb begin
    state_next = state_reg;
    tx_pop     = 1'b0;

    // two flops per pin; clock and data share latency
    state_next.clk_meta = link_clock_in_i;
    state_next.clk_sync = state_reg.clk_meta;
    state_next.clk_prev = state_reg.clk_sync;
    state_next.din_meta = serial_in_line_i;
    state_next.din_sync = state_reg.din_meta;
    state_next.rx_push  = 1'b0;

    if (host_mode_valid_i &&
        (host_mode_value_i == link_pkg::CMD_HOLD)) begin
      state_next.held = 1'b1;
    end
    // release command lets buffered bytes go
    if (host_mode_valid_i &&
        (host_mode_value_i == link_pkg::CMD_RELEASE)) begin
      state_next.held = 1'b0;
    end

    // a start bit already on the line counts as receiving
    rx_busy = (state_reg.rx_state != link_pkg::RX_IDLE) ||
              (state_reg.cts &&
               (state_reg.din_sync == link_pkg::START_BIT));

    // outgoing side moves on falling link edges
    if (link_fall) begin
      unique case (state_reg.tx_state)
        link_pkg::TX_IDLE: begin
          if (txb_valid && !state_reg.held && !rx_busy) begin
            tx_pop              = 1'b1;
            state_next.out_line = link_pkg::START_BIT;
            state_next.tx_shift = {link_pkg::SOURCE_BIT, txb_data};
            state_next.tx_count = link_pkg::COUNT_ZERO;
            state_next.tx_state = link_pkg::TX_SHIFT;
          end
        end
        link_pkg::TX_SHIFT: begin
          // back to idle high after ten bits
          if (state_reg.tx_count == link_pkg::TX_LAST) begin
            state_next.out_line = link_pkg::IDLE_LEVEL;
            state_next.tx_state = link_pkg::TX_IDLE;
          end else begin
            state_next.out_line = state_reg.tx_shift[0];
            state_next.tx_shift = {link_pkg::IDLE_LEVEL,
                                   state_reg.tx_shift[8:1]};
            state_next.tx_count = state_reg.tx_count + 1'b1;
          end
        end
      endcase
    end

    // incoming side samples on rising link edges
    unique case (state_reg.rx_state)
      link_pkg::RX_IDLE: begin
        if (link_rise && state_reg.cts &&
            (state_reg.din_sync == link_pkg::START_BIT)) begin
          state_next.rx_count = link_pkg::COUNT_ZERO;
          state_next.rx_state = link_pkg::RX_DATA;
        end else begin
          // raise cts only with room; push not yet seen
          state_next.cts = rxb_ready && !state_reg.rx_push;
        end
      end
      link_pkg::RX_DATA: begin
        if (link_rise) begin
          // cts falls on the edge after start
          if (state_reg.rx_count == link_pkg::COUNT_ZERO) begin
            state_next.cts = 1'b0;
          end
          state_next.rx_shift = {state_reg.din_sync,
                                 state_reg.rx_shift[7:1]};
          state_next.rx_count = state_reg.rx_count + 1'b1;
          if (state_reg.rx_count == link_pkg::RX_LAST) begin
            state_next.rx_state = link_pkg::RX_DESTINATION_SELECT_BIT;
          end
        end
      end
      link_pkg::RX_DESTINATION_SELECT_BIT: begin
        if (link_rise) begin
          state_next.rx_push  = (state_reg.din_sync ==
                                 link_pkg::DESTINATION_SELECT_BIT_WRITE);
          state_next.rx_state = link_pkg::RX_IDLE;
        end
      end
    endcase

    if (reset_i) begin
      state_next.clk_meta = 1'b0;
      state_next.clk_sync = 1'b0;
      state_next.clk_prev = 1'b0;
      state_next.din_meta = link_pkg::IDLE_LEVEL;
      state_next.din_sync = link_pkg::IDLE_LEVEL;
      state_next.held     = link_pkg::HELD_RESET;
      state_next.tx_state = link_pkg::TX_IDLE;
      state_next.tx_count = link_pkg::COUNT_ZERO;
      state_next.tx_shift = '0;
      state_next.out_line = link_pkg::OUT_RESET;
      state_next.rx_state = link_pkg::RX_IDLE;
      state_next.rx_count = link_pkg::COUNT_ZERO;
      state_next.rx_shift = '0;
      state_next.cts      = link_pkg::CTS_RESET;
      state_next.rx_push  = 1'b0;
      tx_pop              = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state_reg <= state_next;
  end

endmodule

// File: test/serial_link_checker.sv
`timescale 1ns/100ps
module serial_link_checker (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       host_mode_valid_i,
  input wire logic [7:0] host_mode_value_i,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_ready_i,
  input wire logic       link_clock_in_i,
  input wire logic       serial_out_line_o,
  input wire logic       clear_to_send_line_o,
  input wire logic       link_held_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // sync delay puts pin edges 3 to 4 cycles back
  sequence after_rise;
    $past(link_clock_in_i, 2) && !$past(link_clock_in_i, 7);
  endsequence
  sequence after_fall;
    !$past(link_clock_in_i, 2) && $past(link_clock_in_i, 7);
  endsequence
  sequence cts_drop;
    $fell(clear_to_send_line_o) && !$past(reset_i);
  endsequence
  AST_HOLD: assert property (host_mode_valid_i &&
    host_mode_value_i == 8'h10 |=> link_held_o) else $error("no hold");
  AST_RELEASE: assert property (host_mode_valid_i &&
    host_mode_value_i == 8'h00 |=> !link_held_o) else $error("no release");
  AST_CTS_DROP: assert property (cts_drop |-> after_rise)
    else $error("cts drop off rise");
  AST_CTS_LOW: assert property (cts_drop |=>
    !clear_to_send_line_o [*8]) else $error("cts low too short");
  AST_PUSH_CTS: assert property ($rose(rx_valid_o) |->
    !clear_to_send_line_o) else $error("cts high at push");
  AST_OUT_EDGE: assert property ($changed(serial_out_line_o) &&
    !$past(reset_i) |-> after_fall) else $error("out off fall");
  AST_BIT_LEN: assert property ($fell(serial_out_line_o) &&
    !$past(reset_i) |=> !serial_out_line_o [*4]) else $error("short bit");
  AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=>
    rx_valid_o && $stable(rx_data_o)) else $error("rx byte lost");
endmodule
bind serial_link serial_link_checker chk (
  .core_clk_i           (core_clk_i),
  .reset_i              (reset_i),
  .host_mode_valid_i    (host_mode_valid_i),
  .host_mode_value_i    (host_mode_value_i),
  .rx_valid_o           (rx_valid_o),
  .rx_data_o            (rx_data_o),
  .rx_ready_i           (rx_ready_i),
  .link_clock_in_i      (link_clock_in_i),
  .serial_out_line_o    (serial_out_line_o),
  .clear_to_send_line_o (clear_to_send_line_o),
  .link_held_o          (link_held_o)
);

// File: test/far_end.sv
`timescale 1ns/100ps
module far_end (
  output logic      link_clk_o,
  output logic      sin_o,
  input  wire logic sout_i,
  input  wire logic cts_i
);
  // clock stands low, data idles high
  initial begin
    link_clk_o = 1'b0;
    sin_o = 1'b1;
  end
  // stall with clock high after a start bit
  // low 60, high 65: edges land on core falling edges, no race
  task automatic recv(input int stall, output logic found,
                      output logic [7:0] d, output logic src);
    logic [8:0] f;
    found = 1'b0;
    f = '0;
    for (int i = 0; i < 12 && !found; i++) begin
      #60 link_clk_o = 1'b1;
      found = !sout_i;
      if (found) #(stall);
      #65 link_clk_o = 1'b0;
    end
    for (int i = 0; i < 9 && found; i++) begin
      #60 link_clk_o = 1'b1;
      f = {sout_i, f[8:1]};
      #65 link_clk_o = 1'b0;
    end
    {src, d} = f;
  endtask
  // wait for cts, lsb first, destination_select_bit bit last
  task automatic send(input logic [7:0] d, input logic destination_select_bit,
                      output logic quiet);
    logic [9:0] f;
    f = {destination_select_bit, d, 1'b0};
    for (int k = 0; k < 100 && !cts_i; k++) #5;
    quiet = cts_i;
    for (int i = 0; i < 10; i++) begin
      sin_o = f[i];
      #60 link_clk_o = 1'b1;
      quiet &= sout_i;
      #65 link_clk_o = 1'b0;
    end
    // one idle bit so frames never touch
    sin_o = 1'b1;
    #125;
  endtask
endmodule

// File: test/isolated_clocked_serial_link_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fails++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module isolated_clocked_serial_link_test;
  logic       core_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       host_mode_valid_i = 1'b0;
  logic [7:0] host_mode_value_i = 8'h00;
  logic       tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic       rx_ready_i = 1'b0;
  logic       tx_ready_o, rx_valid_o, serial_out_line_o;
  logic       clear_to_send_line_o, link_held_o;
  logic [7:0] rx_data_o, got;
  logic       link_clock_in_i, serial_in_line_i, found, src, quiet;
  int         fails = 0;
  int         check_count = 0;
  serial_link dut (
    .core_clk_i           (core_clk_i),
    .reset_i              (reset_i),
    .host_mode_valid_i    (host_mode_valid_i),
    .host_mode_value_i    (host_mode_value_i),
    .tx_valid_i           (tx_valid_i),
    .tx_data_i            (tx_data_i),
    .tx_ready_o           (tx_ready_o),
    .rx_valid_o           (rx_valid_o),
    .rx_data_o            (rx_data_o),
    .rx_ready_i           (rx_ready_i),
    .link_clock_in_i      (link_clock_in_i),
    .serial_in_line_i     (serial_in_line_i),
    .serial_out_line_o    (serial_out_line_o),
    .clear_to_send_line_o (clear_to_send_line_o),
    .link_held_o          (link_held_o)
  );
  far_end far (
    .link_clk_o (link_clock_in_i),
    .sin_o      (serial_in_line_i),
    .sout_i     (serial_out_line_o),
    .cts_i      (clear_to_send_line_o)
  );
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge core_clk_i);
    tx_valid_i = 1'b1;
    tx_data_i = d;
    for (int i = 0; i < 40 && tx_ready_o !== 1'b1; i++)
      @(negedge core_clk_i);
    `CHK(tx_ready_o, 1'b1)
    @(negedge core_clk_i);
    tx_valid_i = 1'b0;
  endtask
  task automatic pop(input logic [7:0] d);
    @(negedge core_clk_i);
    for (int i = 0; i < 40 && rx_valid_o !== 1'b1; i++)
      @(negedge core_clk_i);
    `CHK(rx_valid_o, 1'b1)
    `CHK(rx_data_o, d)
    rx_ready_i = 1'b1;
    @(negedge core_clk_i);
    rx_ready_i = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] v, input logic held);
    @(negedge core_clk_i);
    host_mode_valid_i = 1'b1;
    host_mode_value_i = v;
    @(negedge core_clk_i);
    host_mode_valid_i = 1'b0;
    @(negedge core_clk_i);
    `CHK(link_held_o, held)
  endtask
  // line settles 3 cycles after the last fall
  task automatic take(input int stall, input logic [7:0] d);
    far.recv(stall, found, got, src);
    #40;
    `CHK(found, 1'b1)
    `CHK(got, d)
    `CHK(src, 1'b0)
    `CHK(serial_out_line_o, 1'b1)
  endtask
  task automatic t_out();
    push(8'hA5);
    push(8'h3C);
    take(500, 8'hA5);
    take(0, 8'h3C);
  endtask
  task automatic t_hold();
    cmd(8'h10, 1'b1);
    push(8'h81);
    push(8'h7E);
    `CHK(tx_ready_o, 1'b0)
    far.recv(0, found, got, src);
    `CHK(found, 1'b0)
    cmd(8'h00, 1'b0);
    take(0, 8'h81);
    take(0, 8'h7E);
  endtask
  task automatic t_in();
    far.send(8'h44, 1'b1, quiet);
    `CHK(quiet, 1'b1)
    #200;
    `CHK(rx_valid_o, 1'b0)
    far.send(8'h5A, 1'b0, quiet);
    far.send(8'hC3, 1'b0, quiet);
    #200;
    `CHK(clear_to_send_line_o, 1'b0)
    pop(8'h5A);
    #50;
    `CHK(clear_to_send_line_o, 1'b1)
    pop(8'hC3);
  endtask
  task automatic t_dup();
    push(8'h96);
    far.send(8'h11, 1'b0, quiet);
    `CHK(quiet, 1'b1)
    take(0, 8'h96);
    pop(8'h11);
  endtask
  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_out();
    t_hold();
    t_in();
    t_dup();
    summarize();
  end
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
